// file: tsc_regs.sv
// tsc_regs: APB register bank for phase-detector trim, dac, bias and two spur channels.
// assumes pclk at 50 MHz; loop_closed comes from the pll core on the same clock.
//
// Design decision made here: register access over APB.
`timescale 1ns/100ps
module tsc_regs (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic loop_closed,
   output logic [5:0] coarse_linear_gain,
   output logic [2:0] coarse_gain_scale,
   output logic [13:0] coarse_detector_gain,
   output logic [7:0] fine_detector_gain,
   output logic [13:0] phase_offset,
   output logic [9:0] dac_current,
   output logic [1:0] bias_sel,
   output logic [4:0] bias_drop_hundred_mv,
   output logic spur1_enable,
   output logic spur1_gain_x2,
   output logic [3:0] spur1_harmonic,
   output logic [7:0] spur1_magnitude,
   output logic [8:0] spur1_phase,
   output logic spur2_enable,
   output logic spur2_gain_x2,
   output logic [3:0] spur2_harmonic,
   output logic [7:0] spur2_magnitude,
   output logic [8:0] spur2_phase
);
   logic [2:0] scale_reg;
   logic [5:0] cgain_reg;
   logic [7:0] fgain_reg;
   logic [7:0] off_lo_reg;
   logic [5:0] off_hi_reg;
   logic [7:0] dac_lo_reg;
   logic [1:0] dac_hi_reg;
   logic [1:0] bias_reg;
   logic [7:0] s1_ctrl_reg;
   logic [7:0] s1_mag_reg;
   logic [7:0] s1_ph_lo_reg;
   logic s1_ph_hi_reg;
   logic [7:0] s2_ctrl_reg;
   logic [7:0] s2_mag_reg;
   logic [7:0] s2_ph_lo_reg;
   logic s2_ph_hi_reg;
   logic [13:0] off_live_reg;
   logic [9:0] dac_live_reg;
   logic [8:0] s1_ph_live_reg;
   logic [8:0] s2_ph_live_reg;
   logic [15:0] idx;
   logic hit;
   logic word_ok;
   logic wr;
   logic rd;
   logic [7:0] rbyte;
   logic [7:0] wb;

   // zero-wait slave; accesses complete in the first access cycle
   assign pready = 1'b1;
   localparam int ADDR_W_HI = tsc_pkg::ADDR_W - 1;
   assign idx = paddr[ADDR_W_HI:2];
   assign word_ok = (paddr[1:0] == 2'h0) && (paddr[31:tsc_pkg::ADDR_W] == '0);
   assign wb = pwdata[7:0];
   assign wr = clk_en && psel && penable && pwrite && word_ok && pstrb[0];
   // read data is latched in the setup cycle so it stands when pready is sampled;
   // clk_en must be high in the setup cycle for a read to return data
   assign rd = clk_en && psel && !penable && !pwrite;

   always_comb begin
      hit = word_ok;
      rbyte = 8'h00;
      if (idx == tsc_pkg::IDX_COARSE_SCALE) begin
         rbyte = {5'h00, scale_reg};
      end else if (idx == tsc_pkg::IDX_COARSE_GAIN) begin
         rbyte = {2'h0, cgain_reg};
      end else if (idx == tsc_pkg::IDX_FINE_GAIN) begin
         rbyte = fgain_reg;
      end else if (idx == tsc_pkg::IDX_REVISION) begin
         rbyte = {tsc_pkg::REVISION_VALUE, 6'h00};
      end else if (idx == tsc_pkg::IDX_OFFSET_LO) begin
         rbyte = off_lo_reg;
      end else if (idx == tsc_pkg::IDX_OFFSET_HI) begin
         rbyte = {2'h0, off_hi_reg};
      end else if (idx == tsc_pkg::IDX_DAC_LO) begin
         rbyte = dac_lo_reg;
      end else if (idx == tsc_pkg::IDX_DAC_HI) begin
         rbyte = {6'h00, dac_hi_reg};
      end else if (idx == tsc_pkg::IDX_BIAS) begin
         rbyte = {6'h00, bias_reg};
      end else if (idx == tsc_pkg::IDX_S1_CTRL) begin
         rbyte = {s1_ctrl_reg[7:6], 2'h0, s1_ctrl_reg[3:0]};
      end else if (idx == tsc_pkg::IDX_S1_MAG) begin
         rbyte = s1_mag_reg;
      end else if (idx == tsc_pkg::IDX_S1_PH_LO) begin
         rbyte = s1_ph_lo_reg;
      end else if (idx == tsc_pkg::IDX_S1_PH_HI) begin
         rbyte = {7'h00, s1_ph_hi_reg};
      end else if (idx == tsc_pkg::IDX_S2_CTRL) begin
         rbyte = {s2_ctrl_reg[7:6], 2'h0, s2_ctrl_reg[3:0]};
      end else if (idx == tsc_pkg::IDX_S2_MAG) begin
         rbyte = s2_mag_reg;
      end else if (idx == tsc_pkg::IDX_S2_PH_LO) begin
         rbyte = s2_ph_lo_reg;
      end else if (idx == tsc_pkg::IDX_S2_PH_HI) begin
         rbyte = {7'h00, s2_ph_hi_reg};
      end else begin
         hit = 1'b0;
      end
   end

   // unmapped addresses: read zero, write ignored, no error so byte maps scan cleanly
   assign pslverr = 1'b0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (rd) begin
         prdata <= hit ? {24'h00_0000, rbyte} : 32'h0000_0000;
      end
   end

   // trim registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scale_reg <= 3'h0;
         cgain_reg <= 6'h00;
         fgain_reg <= tsc_pkg::RESET_BYTE;
         bias_reg <= 2'h0;
      end else if (wr) begin
         if (idx == tsc_pkg::IDX_COARSE_SCALE) begin
            scale_reg <= wb[2:0];
         end else if (idx == tsc_pkg::IDX_COARSE_GAIN) begin
            cgain_reg <= wb[5:0];
         end else if (idx == tsc_pkg::IDX_FINE_GAIN) begin
            fgain_reg <= wb;
         end else if (idx == tsc_pkg::IDX_BIAS) begin
            bias_reg <= wb[1:0];
         end
      end
   end

   // split fields: low bytes are staged, the high byte write publishes the whole value
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         off_lo_reg <= tsc_pkg::RESET_BYTE;
         off_hi_reg <= 6'h00;
         dac_lo_reg <= tsc_pkg::RESET_BYTE;
         dac_hi_reg <= 2'h0;
         off_live_reg <= 14'h0000;
         dac_live_reg <= 10'h000;
      end else if (wr) begin
         if (idx == tsc_pkg::IDX_OFFSET_LO) begin
            off_lo_reg <= wb;
         end else if (idx == tsc_pkg::IDX_OFFSET_HI) begin
            off_hi_reg <= wb[5:0];
            off_live_reg <= {wb[5:0], off_lo_reg};
         end else if (idx == tsc_pkg::IDX_DAC_LO) begin
            dac_lo_reg <= wb;
         end else if (idx == tsc_pkg::IDX_DAC_HI) begin
            dac_hi_reg <= wb[1:0];
            dac_live_reg <= {wb[1:0], dac_lo_reg};
         end
      end
   end

   // spur channels
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_ctrl_reg <= tsc_pkg::RESET_HARM;
         s1_mag_reg <= tsc_pkg::RESET_BYTE;
         s1_ph_lo_reg <= tsc_pkg::RESET_BYTE;
         s1_ph_hi_reg <= 1'b0;
         s1_ph_live_reg <= 9'h000;
         s2_ctrl_reg <= tsc_pkg::RESET_HARM;
         s2_mag_reg <= tsc_pkg::RESET_BYTE;
         s2_ph_lo_reg <= tsc_pkg::RESET_BYTE;
         s2_ph_hi_reg <= 1'b0;
         s2_ph_live_reg <= 9'h000;
      end else if (wr) begin
         if (idx == tsc_pkg::IDX_S1_CTRL) begin
            s1_ctrl_reg <= {wb[7:6], 2'h0, wb[3:0]};
         end else if (idx == tsc_pkg::IDX_S1_MAG) begin
            s1_mag_reg <= wb;
         end else if (idx == tsc_pkg::IDX_S1_PH_LO) begin
            s1_ph_lo_reg <= wb;
         end else if (idx == tsc_pkg::IDX_S1_PH_HI) begin
            s1_ph_hi_reg <= wb[0];
            s1_ph_live_reg <= {wb[0], s1_ph_lo_reg};
         end else if (idx == tsc_pkg::IDX_S2_CTRL) begin
            s2_ctrl_reg <= {wb[7:6], 2'h0, wb[3:0]};
         end else if (idx == tsc_pkg::IDX_S2_MAG) begin
            s2_mag_reg <= wb;
         end else if (idx == tsc_pkg::IDX_S2_PH_LO) begin
            s2_ph_lo_reg <= wb;
         end else if (idx == tsc_pkg::IDX_S2_PH_HI) begin
            s2_ph_hi_reg <= wb[0];
            s2_ph_live_reg <= {wb[0], s2_ph_lo_reg};
         end
      end
   end

   assign coarse_linear_gain = cgain_reg;
   assign coarse_gain_scale = scale_reg;
   // linear gain shifted by the power-of-two scale, widest case 63 << 7
   assign coarse_detector_gain = {8'h00, cgain_reg} << scale_reg;
   assign fine_detector_gain = fgain_reg;
   // open loop gets zero offset, so the pll never sees a stale trim
   assign phase_offset = loop_closed ? off_live_reg : 14'h0000;
   assign dac_current = dac_live_reg;
   assign bias_sel = bias_reg;

   // supply drop in 100 mV steps; the 1.6 V setting needs a fifth bit
   always_comb begin
      case (bias_reg)
         2'h0: bias_drop_hundred_mv = 5'h08;
         2'h1: bias_drop_hundred_mv = 5'h04;
         2'h2: bias_drop_hundred_mv = 5'h10;
         default: bias_drop_hundred_mv = 5'h0C;
      endcase
   end

   assign spur1_enable = s1_ctrl_reg[tsc_pkg::SP_EN_BIT];
   assign spur1_gain_x2 = s1_ctrl_reg[tsc_pkg::SP_X2_BIT];
   // zero is outside 1..15; clamp to the fundamental
   assign spur1_harmonic = (s1_ctrl_reg[3:0] == 4'h0) ? 4'h1 : s1_ctrl_reg[3:0];
   assign spur1_magnitude = s1_mag_reg;
   assign spur1_phase = s1_ph_live_reg;
   assign spur2_enable = s2_ctrl_reg[tsc_pkg::SP_EN_BIT];
   assign spur2_gain_x2 = s2_ctrl_reg[tsc_pkg::SP_X2_BIT];
   assign spur2_harmonic = (s2_ctrl_reg[3:0] == 4'h0) ? 4'h1 : s2_ctrl_reg[3:0];
   assign spur2_magnitude = s2_mag_reg;
   assign spur2_phase = s2_ph_live_reg;

   // bus side: read data must not move under the master while it samples
   rd_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      psel && penable && !pwrite |=> $stable(prdata))
      else $error("read data moved in access phase");
   clk_freeze_a: assert property (@(posedge pclk) disable iff (!presetn)
      !clk_en |=> $stable(prdata) && $stable(fgain_reg) && $stable(s1_ctrl_reg)
      && $stable(off_live_reg) && $stable(dac_live_reg))
      else $error("state moved while frozen");
   // trim, bias, revision and unmapped addresses
   coarse_lin_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr && idx == tsc_pkg::IDX_COARSE_GAIN |=> coarse_linear_gain == $past(wb[5:0]))
      else $error("coarse linear gain not taken");
   coarse_scale_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr && idx == tsc_pkg::IDX_COARSE_SCALE |=> coarse_gain_scale == $past(wb[2:0]))
      else $error("coarse scale not taken");
   coarse_gain_a: assert property (@(posedge pclk) disable iff (!presetn)
      scale_reg == 3'h0 |-> coarse_detector_gain == {8'h00, cgain_reg})
      else $error("coarse gain wrong");
   fine_gain_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr && idx == tsc_pkg::IDX_FINE_GAIN |=> fine_detector_gain == $past(wb))
      else $error("fine gain not taken");
   bias_dec_a: assert property (@(posedge pclk) disable iff (!presetn)
      bias_drop_hundred_mv == (bias_reg == 2'h0 ? 5'h08 : bias_reg == 2'h1 ? 5'h04 :
      bias_reg == 2'h2 ? 5'h10 : 5'h0C)) else $error("bias decode wrong");
   bias_rsv_a: assert property (@(posedge pclk) disable iff (!presetn)
      rd && idx == tsc_pkg::IDX_BIAS |=> prdata[31:2] == 30'h0000_0000)
      else $error("reserved bias bits read back");
   rev_read_a: assert property (@(posedge pclk) disable iff (!presetn)
      rd && idx == tsc_pkg::IDX_REVISION && word_ok |=>
      prdata == {24'h00_0000, tsc_pkg::REVISION_VALUE, 6'h00})
      else $error("revision read wrong");
   unmapped_a: assert property (@(posedge pclk) disable iff (!presetn)
      rd && !hit |=> prdata == 32'h0000_0000) else $error("unmapped read not zero");
   ignore_wr_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr && !hit |=> $stable(cgain_reg) && $stable(fgain_reg) && $stable(s1_ctrl_reg)
      && $stable(s2_ctrl_reg) && $stable(off_lo_reg) && $stable(bias_reg))
      else $error("unmapped write landed");
   // split fields publish on the high byte
   offset_open_a: assert property (@(posedge pclk) disable iff (!presetn)
      !loop_closed |-> phase_offset == 14'h0000) else $error("offset leaks while open");
   offset_pub_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr && idx == tsc_pkg::IDX_OFFSET_HI |=> off_live_reg == {off_hi_reg, off_lo_reg})
      else $error("offset not published");
   offset_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr && idx == tsc_pkg::IDX_OFFSET_LO |=> $stable(off_live_reg))
      else $error("offset changed on low byte");
   dac_pub_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr && idx == tsc_pkg::IDX_DAC_HI |=> dac_current == {dac_hi_reg, dac_lo_reg})
      else $error("dac code not published");
   dac_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr && idx == tsc_pkg::IDX_DAC_LO |=> $stable(dac_current))
      else $error("dac code moved on low byte");
   // spur channels
   spur_en_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr && idx == tsc_pkg::IDX_S1_CTRL |=> spur1_enable == $past(wb[7]))
      else $error("spur one enable wrong");
   spur_x2_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr && idx == tsc_pkg::IDX_S1_CTRL |=> spur1_gain_x2 == $past(wb[6]))
      else $error("spur one doubling wrong");
   spur2_ctl_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr && idx == tsc_pkg::IDX_S2_CTRL |=>
      spur2_enable == $past(wb[7]) && spur2_gain_x2 == $past(wb[6]))
      else $error("spur two control wrong");
   spur_rsv_a: assert property (@(posedge pclk) disable iff (!presetn)
      s1_ctrl_reg[5:4] == 2'h0 && s2_ctrl_reg[5:4] == 2'h0)
      else $error("reserved spur bits set");
   harm_range_a: assert property (@(posedge pclk) disable iff (!presetn)
      spur1_harmonic != 4'h0 && spur2_harmonic != 4'h0) else $error("harmonic zero");
   harm1_pass_a: assert property (@(posedge pclk) disable iff (!presetn)
      s1_ctrl_reg[3:0] != 4'h0 |-> spur1_harmonic == s1_ctrl_reg[3:0])
      else $error("spur one harmonic altered");
   harm2_pass_a: assert property (@(posedge pclk) disable iff (!presetn)
      s2_ctrl_reg[3:0] != 4'h0 |-> spur2_harmonic == s2_ctrl_reg[3:0])
      else $error("spur two harmonic altered");
   spur1_mag_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr && idx == tsc_pkg::IDX_S1_MAG |=> spur1_magnitude == $past(wb))
      else $error("spur one magnitude not taken");
   spur2_mag_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr && idx == tsc_pkg::IDX_S2_MAG |=> spur2_magnitude == $past(wb))
      else $error("spur two magnitude not taken");
   spur1_phase_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr && idx == tsc_pkg::IDX_S1_PH_HI |=> spur1_phase == {$past(wb[0]), s1_ph_lo_reg})
      else $error("spur one phase not published");
   spur1_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr && idx == tsc_pkg::IDX_S1_PH_LO |=> $stable(spur1_phase))
      else $error("spur one phase moved on low byte");
   spur2_phase_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr && idx == tsc_pkg::IDX_S2_PH_HI |=> spur2_phase == {$past(wb[0]), s2_ph_lo_reg})
      else $error("spur two phase not published");
endmodule

// file: tsc_pkg.sv
// tsc_pkg: offsets, field positions and reset values of the trim and spur register bank.
// assumes an APB slave with 32-bit data; each byte register takes one aligned word.
package tsc_pkg;
   // printed offsets are register indices; byte address is four times the index
   localparam logic [15:0] IDX_COARSE_SCALE = 16'h0402;
   localparam logic [15:0] IDX_COARSE_GAIN = 16'h0403;
   localparam logic [15:0] IDX_FINE_GAIN = 16'h0404;
   localparam logic [15:0] IDX_REVISION = 16'h0406;
   localparam logic [15:0] IDX_OFFSET_LO = 16'h0409;
   localparam logic [15:0] IDX_OFFSET_HI = 16'h040A;
   localparam logic [15:0] IDX_DAC_LO = 16'h040B;
   localparam logic [15:0] IDX_DAC_HI = 16'h040C;
   localparam logic [15:0] IDX_BIAS = 16'h040F;
   localparam logic [15:0] IDX_S1_CTRL = 16'h0500;
   localparam logic [15:0] IDX_S1_MAG = 16'h0501;
   localparam logic [15:0] IDX_S1_PH_LO = 16'h0503;
   localparam logic [15:0] IDX_S1_PH_HI = 16'h0504;
   localparam logic [15:0] IDX_S2_CTRL = 16'h0505;
   localparam logic [15:0] IDX_S2_MAG = 16'h0506;
   localparam logic [15:0] IDX_S2_PH_LO = 16'h0508;
   localparam logic [15:0] IDX_S2_PH_HI = 16'h0509;
   localparam int ADDR_W = 18;
   // spur control byte fields
   localparam int SP_EN_BIT = 7;
   localparam int SP_X2_BIT = 6;
   localparam int SP_HARM_MSB = 3;
   // revision field position
   localparam int REV_LSB = 6;
   // revision value is arbitrary
   localparam logic [1:0] REVISION_VALUE = 2'h2;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [7:0] RESET_HARM = 8'h01;
endpackage

// file: tb_top.sv
// tb_top: self-checking bench for the trim and spur register bank, with a byte-map model.
// assumes tsc_pkg and tsc_regs compiled first; the bench is the only apb master.
`timescale 1ns/100ps
module tb_top;
   logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, loop_closed;
   logic [31:0] paddr, pwdata, prdata, rd;
   logic [3:0] pstrb;
   logic [5:0] coarse_linear_gain;
   logic [2:0] coarse_gain_scale;
   logic [13:0] coarse_detector_gain, phase_offset;
   logic [7:0] fine_detector_gain, spur1_magnitude, spur2_magnitude;
   logic [9:0] dac_current;
   logic [1:0] bias_sel;
   logic [4:0] bias_drop_hundred_mv;
   logic [3:0] spur1_harmonic, spur2_harmonic;
   logic spur1_enable, spur1_gain_x2, spur2_enable, spur2_gain_x2;
   logic [8:0] spur1_phase, spur2_phase;
   logic [7:0] mem [int];
   logic [7:0] msk [int];
   logic [7:0] pub [int];
   int error_cnt = 0;
   int cmp_count = 0;
   int cyc = 0;
   int seed;
   int rsv [6] = '{16'h0405, 16'h0407, 16'h040D, 16'h0410, 16'h0502, 16'h0507};
   tsc_regs dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .loop_closed(loop_closed),
      .coarse_linear_gain(coarse_linear_gain), .coarse_gain_scale(coarse_gain_scale),
      .coarse_detector_gain(coarse_detector_gain), .fine_detector_gain(fine_detector_gain),
      .phase_offset(phase_offset), .dac_current(dac_current), .bias_sel(bias_sel),
      .bias_drop_hundred_mv(bias_drop_hundred_mv), .spur1_enable(spur1_enable),
      .spur1_gain_x2(spur1_gain_x2), .spur1_harmonic(spur1_harmonic),
      .spur1_magnitude(spur1_magnitude), .spur1_phase(spur1_phase),
      .spur2_enable(spur2_enable), .spur2_gain_x2(spur2_gain_x2),
      .spur2_harmonic(spur2_harmonic), .spur2_magnitude(spur2_magnitude),
      .spur2_phase(spur2_phase));
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 5000) begin
         error_cnt++;
         give_verdict;
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // one apb transfer; the model follows only writes with byte lane 0 to mapped places
   task automatic apb(input bit wr, input int idx, input logic [7:0] d, input logic [3:0] st);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= 32'(idx) << 2;
      pwdata <= {$random(seed)} & 32'hFFFFFF00 | 32'(d);
      pstrb <= st;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      check(pslverr, 0);
      psel <= 1'b0;
      penable <= 1'b0;
      // a frozen block acknowledges the write but drops it
      if (wr && st[0] && clk_en && msk.exists(idx)) begin
         mem[idx] = mem[idx] & ~msk[idx] | d & msk[idx];
         if (idx inside {tsc_pkg::IDX_OFFSET_HI, tsc_pkg::IDX_DAC_HI, tsc_pkg::IDX_S1_PH_HI,
               tsc_pkg::IDX_S2_PH_HI}) begin
            pub[idx - 1] = mem[idx - 1];
         end
      end
   endtask
   task automatic chk_outs;
      logic [7:0] c1, c2, b;
      @(negedge pclk);
      c1 = mem[tsc_pkg::IDX_S1_CTRL];
      c2 = mem[tsc_pkg::IDX_S2_CTRL];
      b = mem[tsc_pkg::IDX_BIAS];
      check(coarse_linear_gain, mem[tsc_pkg::IDX_COARSE_GAIN]);
      check(coarse_gain_scale, mem[tsc_pkg::IDX_COARSE_SCALE]);
      check(coarse_detector_gain,
         mem[tsc_pkg::IDX_COARSE_GAIN] << mem[tsc_pkg::IDX_COARSE_SCALE]);
      check(fine_detector_gain, mem[tsc_pkg::IDX_FINE_GAIN]);
      check(phase_offset, loop_closed ? {mem[tsc_pkg::IDX_OFFSET_HI],
         pub[tsc_pkg::IDX_OFFSET_LO]} : 0);
      check(dac_current, {mem[tsc_pkg::IDX_DAC_HI], pub[tsc_pkg::IDX_DAC_LO]});
      check(bias_sel, b);
      check(bias_drop_hundred_mv, b == 0 ? 8 : b == 1 ? 4 : b == 2 ? 16 : 12);
      check({spur1_enable, spur1_gain_x2}, c1[7:6]);
      check(spur1_harmonic, c1[3:0] == 0 ? 1 : c1[3:0]);
      check(spur1_magnitude, mem[tsc_pkg::IDX_S1_MAG]);
      check(spur1_phase, {mem[tsc_pkg::IDX_S1_PH_HI], pub[tsc_pkg::IDX_S1_PH_LO]});
      check({spur2_enable, spur2_gain_x2}, c2[7:6]);
      check(spur2_harmonic, c2[3:0] == 0 ? 1 : c2[3:0]);
      check(spur2_magnitude, mem[tsc_pkg::IDX_S2_MAG]);
      check(spur2_phase, {mem[tsc_pkg::IDX_S2_PH_HI], pub[tsc_pkg::IDX_S2_PH_LO]});
   endtask
   initial begin
      seed = 32'hC43C;
      {presetn, psel, penable, pwrite, pstrb, paddr, pwdata} = '0;
      clk_en = 1'b1;
      loop_closed = 1'b1;
      msk = '{16'h0402: 8'h07, 16'h0403: 8'h3F, 16'h0404: 8'hFF, 16'h0406: 8'h00,
         16'h0409: 8'hFF, 16'h040A: 8'h3F, 16'h040B: 8'hFF, 16'h040C: 8'h03, 16'h040F: 8'h03,
         16'h0500: 8'hCF, 16'h0501: 8'hFF, 16'h0503: 8'hFF, 16'h0504: 8'h01, 16'h0505: 8'hCF,
         16'h0506: 8'hFF, 16'h0508: 8'hFF, 16'h0509: 8'h01};
      foreach (msk[i]) begin
         mem[i] = 8'h00;
         pub[i] = 8'h00;
      end
      mem[tsc_pkg::IDX_REVISION] = {tsc_pkg::REVISION_VALUE, 6'h00};
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      chk_outs;
      // random rounds, loop open and closed in turn, ro register written too
      for (int r = 0; r < 4; r++) begin
         @(posedge pclk);
         loop_closed <= r[0];
         foreach (msk[i]) apb(1, i, 8'($random(seed)), 4'hF);
         chk_outs;
         foreach (msk[i]) begin
            apb(0, i, 8'h00, 4'hF);
            check(rd, {24'h0, mem[i]});
         end
      end
      loop_closed <= 1'b1;
      // low byte alone must not move the split field
      apb(1, tsc_pkg::IDX_OFFSET_LO, 8'hA5, 4'hF);
      apb(1, tsc_pkg::IDX_DAC_LO, 8'h5A, 4'hF);
      chk_outs;
      apb(1, tsc_pkg::IDX_OFFSET_HI, 8'hFF, 4'hF);
      apb(1, tsc_pkg::IDX_DAC_HI, 8'hFF, 4'hF);
      chk_outs;
      foreach (msk[i]) apb(1, i, 8'hFF, 4'hE);
      chk_outs;
      foreach (rsv[j]) begin
         apb(1, rsv[j], 8'hFF, 4'hF);
         apb(0, rsv[j], 8'h00, 4'hF);
         check(rd, 32'h0);
      end
      chk_outs;
      for (int b = 0; b < 4; b++) begin
         apb(1, tsc_pkg::IDX_BIAS, {6'h3F, 2'(b)}, 4'hF);
         chk_outs;
      end
      apb(1, tsc_pkg::IDX_S1_CTRL, 8'hC0, 4'hF);
      apb(1, tsc_pkg::IDX_S2_CTRL, 8'h3F, 4'hF);
      chk_outs;
      apb(0, 16'h0410, 8'h00, 4'hF);
      check(rd, 32'h0);
      apb(0, tsc_pkg::IDX_S2_CTRL, 8'h00, 4'hF);
      check(rd, 32'h0000000F);
      // frozen block: the write completes on the bus but must not land
      clk_en <= 1'b0;
      apb(1, tsc_pkg::IDX_FINE_GAIN, ~mem[tsc_pkg::IDX_FINE_GAIN], 4'hF);
      clk_en <= 1'b1;
      apb(0, tsc_pkg::IDX_FINE_GAIN, 8'h00, 4'hF);
      check(rd, {24'h0, mem[tsc_pkg::IDX_FINE_GAIN]});
      chk_outs;
      give_verdict;
   end
endmodule
